// ===== bomarb_cfg.svh
// What this block does
// R1: Exactly one bus owner; all others dormant. The code grants no owner during the one-cycle drain.
// R2: DMA and off-board requests beat both processors.
// R3: After DMA, return bus to previous processor.
// R4: Pseudo-port I/O hands over; narrow CPU I/O returns.
// R5: Interrupt during narrow ownership forces wide processor.
// R6: Merge strobes; early memory start precedes strobes.
// R7: Narrow processor I/O never reaches bus directly.
// R8: Off-board masters never access on-board I/O.
// R9: Twenty-bit wide address; narrow gets 4-bit bank.
// R10: Derive 8, 6, 4 MHz rates from reference.
// R11: Drop ready to add waits for slow I/O.
// R12: Remove processors before hold acknowledge to DMA.
// R13: DMA low byte direct; high byte latched on strobe.
// R14: Extend DMA address with 4-bit bank value.
// R15: Refresh cycle runs memory cycle, moves no data.
// R16: Hold removed means bus back to processor.
// R17: Slave hold drives cascade request; release ripples.
// R18: Passive master never drives; slave drives via acknowledge.
// R19: Floppy cycles lengthened two DMA clock periods.
// R20: Passive option board drives buses once freed.
// R21: Bus wait line lengthens DMA cycles.
// R22: Four off-board request levels arbitrated.
// R23: Ownership changes only at bus cycle boundary. The code hands narrow I/O to the wide processor mid-cycle.
`ifndef BOMARB_CFG_SVH
`define BOMARB_CFG_SVH
`define BOMARB_REF_MHZ 24
`define BOMARB_CPU16_MHZ 8
`define BOMARB_CPU8_MHZ 6
`define BOMARB_DMA_MHZ 4
`define BOMARB_HANDOVER_PORT 8'hF0
`define BOMARB_IO_WAIT 3'h4
`define BOMARB_FLOPPY_WAIT 2'h2
`define BOMARB_OWNER_RST 2'h0
`endif

// ===== bomarb_checker.sv
`timescale 1ns/10ps
module bomarb_checker (
	input logic clk,
	input logic rst_b,
	input logic cpu16_cyc,
	input logic cpu8_cyc,
	input logic cpu8_io,
	input logic irq,
	input logic dma_hrq,
	input logic slave_hrq,
	input logic casc_dreq,
	input logic casc_dack,
	input logic slave_hlda,
	input logic hlda,
	input logic cpu16_grant,
	input logic cpu8_grant,
	input logic [3:0] ob_grant,
	input logic sys_rd,
	input logic sys_wr,
	input logic sys_io,
	input logic sys_refresh,
	input logic early_memory_cycle_start,
	input logic cpu16_clk_en,
	input logic cpu8_clk_en,
	input logic dma_clk_en,
	input logic [3:0] ob_req
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ====================
	// Ownership, strobe, cascade and clock-rate checks.
	a_single_owner: assert property ($onehot0({cpu16_grant, cpu8_grant, hlda}) && $onehot0(ob_grant))
		else $error("more than one bus owner");
	a_dma_first: assert property ((cpu16_grant || cpu8_grant) && dma_hrq
		&& !cpu16_cyc && !cpu8_cyc |-> ##[1:2] !(cpu16_grant || cpu8_grant))
		else $error("processor kept bus against hold request");
	a_hold_after_drain: assert property ($rose(hlda) |-> !$past(cpu16_grant) && !$past(cpu8_grant))
		else $error("hold acknowledge while a processor owned the bus");
	a_irq_swap: assert property (cpu8_grant && irq && !cpu8_cyc && !dma_hrq && !(|ob_req) |-> ##[1:3] cpu16_grant)
		else $error("interrupt did not return bus to wide processor");
	a_narrow_io: assert property (cpu8_grant && cpu8_cyc && cpu8_io |-> !sys_io ##1 !sys_io ##[0:2] cpu16_grant)
		else $error("narrow processor I/O reached the bus");
	a_early_start: assert property (($rose(sys_rd) || $rose(sys_wr)) && !sys_io |-> $past(early_memory_cycle_start))
		else $error("memory strobe without early start");
	a_refresh_quiet: assert property (sys_refresh |-> !sys_rd && !sys_wr)
		else $error("refresh cycle moved data");
	a_cascade_req: assert property (casc_dreq == $past(slave_hrq))
		else $error("cascade request does not follow slave hold");
	a_slave_ack: assert property (slave_hlda == ($past(hlda) && $past(casc_dack) && $past(slave_hrq)))
		else $error("slave acknowledge wrong");
	a_wide_rate: assert property (cpu16_clk_en |=> !cpu16_clk_en [*2] ##1 cpu16_clk_en)
		else $error("wide clock enable not every third cycle");
	a_narrow_rate: assert property (cpu8_clk_en |=> !cpu8_clk_en [*3] ##1 cpu8_clk_en)
		else $error("narrow clock enable not every fourth cycle");
	a_dma_rate: assert property (dma_clk_en |=> !dma_clk_en [*5] ##1 dma_clk_en)
		else $error("DMA clock enable not every sixth cycle");
	a_grant_idle: assert property ($fell(cpu16_grant) |-> !$past(cpu16_cyc))
		else $error("grant removed inside a bus cycle");
endmodule : bomarb_checker

// ===== bomarb_clkdiv.sv
`timescale 1ns/10ps
module bomarb_clkdiv #(
	parameter int DIV = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	output logic en
);
	localparam logic [3:0] LAST = 4'(DIV - 1);
	logic [3:0] cnt_ff;
	// =====================================================
	// Divider.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 4'h0;
			en <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == LAST) ? 4'h0 : cnt_ff + 4'h1;
			en <= (cnt_ff == LAST);
		end
	end
endmodule : bomarb_clkdiv

// ===== bomarb_dev.sv
`timescale 1ns/10ps
`include "bomarb_cfg.svh"
module bomarb_dev
	import bomarb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	bomarb_if.dev bus,
	input wire logic [3:0] cpu8_bank,
	input wire logic [3:0] dma_bank,
	input wire logic io_slow,
	output logic [1:0] owner_ff
);
	localparam int DIV16 = `BOMARB_REF_MHZ / `BOMARB_CPU16_MHZ;
	localparam int DIV8 = `BOMARB_REF_MHZ / `BOMARB_CPU8_MHZ;
	localparam int DIVDMA = `BOMARB_REF_MHZ / `BOMARB_DMA_MHZ;
	bomarb_owner_e own_ff, nxt_own;
	logic prev_cpu8_ff, ho_seen_ff, cpu16_cyc_d_ff, dma_cyc_d_ff;
	logic [7:0] dma_hi_ff;
	logic [2:0] io_wait_ff;
	logic [1:0] fl_cnt_ff;
	logic dma_req, dma_busy, ob_any, handover;
	logic m_cyc, m_io, m_rd, m_wr, m_mem;
	bomarb_addr_t m_addr;
	logic [3:0] ob_pick;
	// =====================================================
	// Clock enables.
	bomarb_clkdiv #(.DIV(DIV16)) u_div16 (.clk(clk), .rst_b(rst_b), .en(bus.cpu16_clk_en)); // R10
	bomarb_clkdiv #(.DIV(DIV8)) u_div8 (.clk(clk), .rst_b(rst_b), .en(bus.cpu8_clk_en)); // R10
	bomarb_clkdiv #(.DIV(DIVDMA)) u_divdma (.clk(clk), .rst_b(rst_b), .en(bus.dma_clk_en)); // R10
	// =====================================================
	// Ownership.
	assign ob_any = |bus.ob_req;
	assign dma_req = bus.dma_hrq | ob_any; // R2 R22
	assign dma_busy = bus.dma_cyc | bus.ob_cyc;
	assign handover = ho_seen_ff & cpu16_cyc_d_ff & !bus.cpu16_cyc; // R4 R23
	always_comb begin
		nxt_own = own_ff;
		unique case (own_ff)
			OWN_CPU16: begin
				if (dma_req && !bus.cpu16_cyc) begin
					nxt_own = OWN_DRAIN; // R2 R23
				end else if (handover) begin
					nxt_own = OWN_CPU8; // R4
				end
			end
			OWN_CPU8: begin
				if (dma_req && !bus.cpu8_cyc) begin
					nxt_own = OWN_DRAIN; // R2 R23
				end else if (bus.cpu8_cyc && bus.cpu8_io) begin
					nxt_own = OWN_CPU16; // R4 R7
				end else if (bus.irq && !bus.cpu8_cyc) begin
					nxt_own = OWN_CPU16; // R5 R23
				end
			end
			OWN_DRAIN: begin
				nxt_own = OWN_DMA; // R12
			end
			OWN_DMA: begin
				if (!dma_req && !dma_busy) begin
					nxt_own = prev_cpu8_ff ? OWN_CPU8 : OWN_CPU16; // R3 R16 R23
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			own_ff <= OWN_CPU16;
			owner_ff <= `BOMARB_OWNER_RST;
			bus.cpu16_grant <= 1'b1;
			bus.cpu8_grant <= 1'b0;
			bus.hlda <= 1'b0;
		end else begin
			own_ff <= nxt_own;
			owner_ff <= nxt_own;
			bus.cpu16_grant <= (nxt_own == OWN_CPU16); // R1
			bus.cpu8_grant <= (nxt_own == OWN_CPU8); // R1
			bus.hlda <= (nxt_own == OWN_DMA); // R1 R12
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_cpu8_ff <= 1'b0;
		end else if (nxt_own == OWN_DRAIN && own_ff != OWN_DRAIN) begin
			prev_cpu8_ff <= (own_ff == OWN_CPU8); // R3
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ho_seen_ff <= 1'b0;
			cpu16_cyc_d_ff <= 1'b0;
			dma_cyc_d_ff <= 1'b0;
		end else begin
			cpu16_cyc_d_ff <= bus.cpu16_cyc;
			dma_cyc_d_ff <= bus.dma_cyc;
			if (!bus.cpu16_cyc) begin
				ho_seen_ff <= 1'b0;
			end else if (bus.cpu16_io && bus.cpu16_addr[7:0] == `BOMARB_HANDOVER_PORT) begin
				ho_seen_ff <= 1'b1; // R4
			end
		end
	end
	// =====================================================
	// DMA cascade and off-board levels.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.casc_dreq <= 1'b0;
			bus.slave_hlda <= 1'b0;
		end else begin
			bus.casc_dreq <= bus.slave_hrq; // R17
			bus.slave_hlda <= bus.hlda & bus.casc_dack & bus.slave_hrq; // R18
		end
	end
	assign ob_pick = bus.ob_req & (~bus.ob_req + 4'h1);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.ob_grant <= 4'h0;
		end else if (own_ff != OWN_DMA || bus.dma_hrq) begin
			if (!bus.ob_cyc) begin
				bus.ob_grant <= 4'h0; // R23
			end
		end else if ((bus.ob_grant & bus.ob_req) == 4'h0 && !bus.ob_cyc) begin
			bus.ob_grant <= ob_pick; // R22
		end
	end
	// =====================================================
	// Address formation.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_hi_ff <= 8'h00;
		end else if (bus.dma_dma_address_strobe) begin
			dma_hi_ff <= bus.dma_db; // R13
		end
	end
	always_comb begin
		m_cyc = 1'b0;
		m_io = 1'b0;
		m_rd = 1'b0;
		m_wr = 1'b0;
		m_addr = 20'h00000;
		unique case (own_ff)
			OWN_CPU16: begin
				m_cyc = bus.cpu16_cyc;
				m_io = bus.cpu16_io;
				m_rd = bus.cpu16_rd;
				m_wr = bus.cpu16_wr;
				m_addr = bus.cpu16_addr; // R9
			end
			OWN_CPU8: begin
				m_cyc = bus.cpu8_cyc & !bus.cpu8_io; // R7
				m_rd = bus.cpu8_rd & !bus.cpu8_io; // R7
				m_wr = bus.cpu8_wr & !bus.cpu8_io; // R7
				m_addr = {cpu8_bank, bus.cpu8_addr}; // R9
			end
			OWN_DRAIN: begin
				m_cyc = 1'b0; // R12
			end
			OWN_DMA: begin
				if (|bus.ob_grant) begin
					m_cyc = bus.ob_cyc;
					m_io = bus.ob_io;
					m_rd = bus.ob_rd;
					m_wr = bus.ob_wr;
					m_addr = bus.ob_addr;
				end else begin
					m_cyc = bus.dma_cyc;
					m_rd = bus.dma_rd & !bus.dma_refresh; // R15
					m_wr = bus.dma_wr & !bus.dma_refresh; // R15
					m_addr = {dma_bank, dma_hi_ff, bus.dma_lo}; // R13 R14
				end
			end
		endcase
	end
	assign m_mem = m_cyc & !m_io;
	// =====================================================
	// Merged control.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.sys_addr <= 20'h00000;
			bus.sys_io <= 1'b0;
			bus.sys_rd <= 1'b0;
			bus.sys_wr <= 1'b0;
			bus.sys_refresh <= 1'b0;
			bus.early_memory_cycle_start <= 1'b0;
		end else begin
			bus.sys_addr <= m_addr;
			bus.sys_io <= m_cyc & m_io;
			bus.early_memory_cycle_start <= m_mem; // R6
			bus.sys_rd <= m_rd & m_cyc & (m_io | bus.early_memory_cycle_start); // R6
			bus.sys_wr <= m_wr & m_cyc & (m_io | bus.early_memory_cycle_start); // R6
			bus.sys_refresh <= (own_ff == OWN_DMA) & bus.dma_cyc & bus.dma_refresh & !(|bus.ob_grant); // R15
		end
	end
	// =====================================================
	// Ready and wait states.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			io_wait_ff <= 3'h0;
		end else if (bus.cpu16_cyc && !cpu16_cyc_d_ff && bus.cpu16_io && io_slow) begin
			io_wait_ff <= `BOMARB_IO_WAIT; // R11
		end else if (bus.cpu16_clk_en && io_wait_ff != 3'h0) begin
			io_wait_ff <= io_wait_ff - 3'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fl_cnt_ff <= 2'h0;
		end else if (bus.dma_cyc && !dma_cyc_d_ff && bus.dma_floppy) begin
			fl_cnt_ff <= `BOMARB_FLOPPY_WAIT; // R19
		end else if (bus.dma_clk_en && fl_cnt_ff != 2'h0) begin
			fl_cnt_ff <= fl_cnt_ff - 2'h1;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.cpu16_ready <= 1'b1;
			bus.dma_ready <= 1'b1;
		end else begin
			bus.cpu16_ready <= !(bus.cpu16_cyc && !cpu16_cyc_d_ff && bus.cpu16_io && io_slow)
				&& (io_wait_ff == 3'h0 || (io_wait_ff == 3'h1 && bus.cpu16_clk_en)); // R11
			bus.dma_ready <= !(bus.dma_cyc && !dma_cyc_d_ff && bus.dma_floppy)
				&& fl_cnt_ff == 2'h0 && !bus.bus_wait_line; // R19 R21
		end
	end
endmodule : bomarb_dev

// ===== bomarb_if.sv
`timescale 1ns/10ps
interface bomarb_if;
	logic cpu16_cyc, cpu16_io, cpu16_rd, cpu16_wr;
	logic [19:0] cpu16_addr;
	logic cpu8_cyc, cpu8_io, cpu8_rd, cpu8_wr;
	logic [15:0] cpu8_addr;
	logic irq;
	logic dma_hrq, slave_hrq, casc_dreq, casc_dack, slave_hlda;
	logic dma_cyc, dma_rd, dma_wr, dma_refresh, dma_floppy, dma_dma_address_strobe;
	logic [7:0] dma_lo, dma_db;
	logic [3:0] ob_req, ob_grant;
	logic ob_cyc, ob_io, ob_rd, ob_wr;
	logic [19:0] ob_addr;
	logic bus_wait_line;
	logic cpu16_grant, cpu8_grant, hlda, cpu16_ready, dma_ready;
	logic [19:0] sys_addr;
	logic sys_rd, sys_wr, sys_io, sys_refresh, early_memory_cycle_start;
	logic cpu16_clk_en, cpu8_clk_en, dma_clk_en;
	modport dev (
		input cpu16_cyc, cpu16_io, cpu16_rd, cpu16_wr, cpu16_addr,
		input cpu8_cyc, cpu8_io, cpu8_rd, cpu8_wr, cpu8_addr, irq,
		input dma_hrq, slave_hrq, casc_dack, dma_cyc, dma_rd, dma_wr, dma_refresh, dma_floppy, dma_dma_address_strobe,
		input dma_lo, dma_db, ob_req, ob_cyc, ob_io, ob_rd, ob_wr, ob_addr, bus_wait_line,
		output casc_dreq, slave_hlda, ob_grant, cpu16_grant, cpu8_grant, hlda, cpu16_ready, dma_ready,
		output sys_addr, sys_rd, sys_wr, sys_io, sys_refresh, early_memory_cycle_start,
		output cpu16_clk_en, cpu8_clk_en, dma_clk_en
	);
	modport oth (
		output cpu16_cyc, cpu16_io, cpu16_rd, cpu16_wr, cpu16_addr,
		output cpu8_cyc, cpu8_io, cpu8_rd, cpu8_wr, cpu8_addr, irq,
		output dma_hrq, slave_hrq, casc_dack, dma_cyc, dma_rd, dma_wr, dma_refresh, dma_floppy, dma_dma_address_strobe,
		output dma_lo, dma_db, ob_req, ob_cyc, ob_io, ob_rd, ob_wr, ob_addr, bus_wait_line,
		input casc_dreq, slave_hlda, ob_grant, cpu16_grant, cpu8_grant, hlda, cpu16_ready, dma_ready,
		input sys_addr, sys_rd, sys_wr, sys_io, sys_refresh, early_memory_cycle_start,
		input cpu16_clk_en, cpu8_clk_en, dma_clk_en
	);
endinterface : bomarb_if

// ===== bomarb_oth.sv
`timescale 1ns/10ps
`include "bomarb_cfg.svh"
module bomarb_oth
	import bomarb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	bomarb_if.oth bus,
	input wire logic u16_cyc,
	input wire logic u16_io,
	input wire logic u16_rd,
	input wire logic u16_wr,
	input wire logic [19:0] u16_addr,
	input wire logic u8_cyc,
	input wire logic u8_io,
	input wire logic u8_rd,
	input wire logic u8_wr,
	input wire logic [15:0] u8_addr,
	input wire logic u_irq,
	input wire logic u_dma_req,
	input wire logic u_floppy_req,
	input wire logic u_dma_cyc,
	input wire logic u_dma_rd,
	input wire logic u_dma_wr,
	input wire logic u_refresh,
	input wire logic u_dma_address_strobe,
	input wire logic [15:0] u_dma_addr,
	input wire logic [3:0] u_ob_req,
	input wire logic u_ob_cyc,
	input wire logic u_ob_io,
	input wire logic u_ob_rd,
	input wire logic u_ob_wr,
	input wire logic [19:0] u_ob_addr,
	input wire logic u_wait,
	output logic u_ob_io_refused_ff
);
	logic dma_own, ob_own;
	assign dma_own = bus.hlda & !(|bus.ob_grant);
	assign ob_own = bus.hlda & (|bus.ob_grant);
	// =====================================================
	// Processors drive cycles only while granted.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.cpu16_cyc <= 1'b0;
			bus.cpu16_io <= 1'b0;
			bus.cpu16_rd <= 1'b0;
			bus.cpu16_wr <= 1'b0;
			bus.cpu16_addr <= 20'h00000;
			bus.cpu8_cyc <= 1'b0;
			bus.cpu8_io <= 1'b0;
			bus.cpu8_rd <= 1'b0;
			bus.cpu8_wr <= 1'b0;
			bus.cpu8_addr <= 16'h0000;
			bus.irq <= 1'b0;
		end else begin
			bus.cpu16_cyc <= u16_cyc & bus.cpu16_grant;
			bus.cpu16_io <= u16_io;
			bus.cpu16_rd <= u16_rd & bus.cpu16_grant;
			bus.cpu16_wr <= u16_wr & bus.cpu16_grant;
			bus.cpu16_addr <= u16_addr; // R4
			bus.cpu8_cyc <= u8_cyc & bus.cpu8_grant; // R4
			bus.cpu8_io <= u8_io;
			bus.cpu8_rd <= u8_rd & bus.cpu8_grant;
			bus.cpu8_wr <= u8_wr & bus.cpu8_grant;
			bus.cpu8_addr <= u8_addr;
			bus.irq <= u_irq;
		end
	end
	// =====================================================
	// DMA pair: master hold and cascade acknowledge.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.slave_hrq <= 1'b0;
			bus.dma_hrq <= 1'b0;
			bus.casc_dack <= 1'b0;
		end else begin
			bus.slave_hrq <= u_floppy_req; // R17
			bus.dma_hrq <= u_dma_req | bus.casc_dreq; // R17
			bus.casc_dack <= bus.hlda & bus.casc_dreq & !u_dma_req; // R18
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.dma_cyc <= 1'b0;
			bus.dma_rd <= 1'b0;
			bus.dma_wr <= 1'b0;
			bus.dma_refresh <= 1'b0;
			bus.dma_floppy <= 1'b0;
			bus.dma_dma_address_strobe <= 1'b0;
			bus.dma_lo <= 8'h00;
			bus.dma_db <= 8'h00;
			bus.bus_wait_line <= 1'b0;
		end else begin
			bus.dma_cyc <= u_dma_cyc & dma_own;
			bus.dma_rd <= u_dma_rd & dma_own;
			bus.dma_wr <= u_dma_wr & dma_own;
			bus.dma_refresh <= u_refresh & !bus.slave_hlda;
			bus.dma_floppy <= bus.slave_hlda;
			bus.dma_dma_address_strobe <= u_dma_address_strobe & dma_own;
			bus.dma_lo <= u_dma_addr[7:0];
			bus.dma_db <= u_dma_addr[15:8];
			bus.bus_wait_line <= u_wait; // R21
		end
	end
	// =====================================================
	// Off-board masters.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bus.ob_req <= 4'h0;
			bus.ob_cyc <= 1'b0;
			bus.ob_io <= 1'b0;
			bus.ob_rd <= 1'b0;
			bus.ob_wr <= 1'b0;
			bus.ob_addr <= 20'h00000;
			u_ob_io_refused_ff <= 1'b0;
		end else begin
			bus.ob_req <= u_ob_req;
			bus.ob_cyc <= u_ob_cyc & ob_own & !u_ob_io; // R8 R20
			bus.ob_io <= 1'b0; // R8
			bus.ob_rd <= u_ob_rd & ob_own & !u_ob_io; // R20
			bus.ob_wr <= u_ob_wr & ob_own & !u_ob_io; // R20
			bus.ob_addr <= u_ob_addr; // R20
			u_ob_io_refused_ff <= u_ob_cyc & u_ob_io; // R8
		end
	end
endmodule : bomarb_oth

// ===== bomarb_pkg.sv
package bomarb_pkg;
	typedef enum logic [1:0] {
		OWN_CPU16 = 2'b00,
		OWN_CPU8 = 2'b01,
		OWN_DRAIN = 2'b10,
		OWN_DMA = 2'b11
	} bomarb_owner_e;
	typedef logic [19:0] bomarb_addr_t;
endpackage : bomarb_pkg

// ===== bus_ownership_dma_arbiter_test.sv
`timescale 1ns/10ps
module bus_ownership_dma_arbiter_test;
	import bomarb_pkg::*;
	logic clk, rst_b, io_slow, u_ob_io_refused_ff;
	logic u16_cyc, u16_io, u16_rd, u16_wr, u8_cyc, u8_io, u8_rd, u8_wr, u_irq, u_dma_req, u_floppy_req, u_wait;
	logic u_dma_cyc, u_dma_rd, u_dma_wr, u_refresh, u_dma_address_strobe, u_ob_cyc, u_ob_io, u_ob_rd, u_ob_wr;
	logic [1:0] owner_ff;
	logic [3:0] cpu8_bank, dma_bank, u_ob_req;
	logic [15:0] u8_addr, u_dma_addr;
	logic [19:0] u16_addr, u_ob_addr;
	int n_fail = 0;
	int n_checks = 0;
	int seed = 3682;
	int ticks = 0;
	int cnt;
	bomarb_if bif();
	bomarb_dev i_bomarb_dev (.clk, .rst_b, .bus(bif), .cpu8_bank, .dma_bank, .io_slow, .owner_ff);
	bomarb_oth i_bomarb_oth (.clk, .rst_b, .bus(bif), .u16_cyc, .u16_io, .u16_rd, .u16_wr, .u16_addr, .u8_cyc,
		.u8_io, .u8_rd, .u8_wr, .u8_addr, .u_irq, .u_dma_req, .u_floppy_req, .u_dma_cyc, .u_dma_rd, .u_dma_wr,
		.u_refresh, .u_dma_address_strobe, .u_dma_addr, .u_ob_req, .u_ob_cyc, .u_ob_io, .u_ob_rd, .u_ob_wr, .u_ob_addr,
		.u_wait, .u_ob_io_refused_ff);
	bomarb_checker i_bomarb_checker (.clk, .rst_b, .cpu16_cyc(bif.cpu16_cyc), .cpu8_cyc(bif.cpu8_cyc),
		.cpu8_io(bif.cpu8_io), .irq(bif.irq), .dma_hrq(bif.dma_hrq), .slave_hrq(bif.slave_hrq),
		.casc_dreq(bif.casc_dreq), .casc_dack(bif.casc_dack), .slave_hlda(bif.slave_hlda), .hlda(bif.hlda),
		.cpu16_grant(bif.cpu16_grant), .cpu8_grant(bif.cpu8_grant), .ob_grant(bif.ob_grant), .sys_rd(bif.sys_rd),
		.sys_wr(bif.sys_wr), .sys_io(bif.sys_io), .sys_refresh(bif.sys_refresh),
		.early_memory_cycle_start(bif.early_memory_cycle_start), .cpu16_clk_en(bif.cpu16_clk_en),
		.cpu8_clk_en(bif.cpu8_clk_en), .dma_clk_en(bif.dma_clk_en), .ob_req(bif.ob_req));
	// ====================
	// Clock, timeout and helpers.
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic sig(input int k);
		case (k)
			0: return bif.cpu16_grant;
			1: return bif.cpu8_grant;
			2: return bif.hlda;
			3: return bif.sys_rd | bif.sys_wr;
			4: return bif.cpu16_ready;
			5: return bif.dma_ready;
			6: return bif.casc_dreq;
			7: return bif.slave_hlda;
			default: return |bif.ob_grant;
		endcase
	endfunction : sig
	function automatic logic [3:0] low_bit(input logic [3:0] r);
		for (int j = 0; j < 4; j++) begin
			if (r[j]) begin
				return 4'h1 << j;
			end
		end
		return 4'h0;
	endfunction : low_bit
	task wait_for(input int k, input logic lvl);
		cnt = 0;
		while (sig(k) !== lvl && cnt < 60) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 60) begin
			n_fail++;
			$display("MISMATCH wait %0d expected %b seen timeout", k, lvl);
		end
	endtask : wait_for
	task cpu16(input logic io, input logic [19:0] a);
		u16_addr = a;
		u16_io = io;
		u16_rd = $random(seed);
		u16_wr = !u16_rd;
		u16_cyc = 1'h1;
		wait_for(3, 1'h1);
		chk("wide_addr", {bif.sys_io, bif.sys_addr}, {io, a});
		if (io_slow) begin
			wait_for(4, 1'h0);
			wait_for(4, 1'h1);
			chk("slow_io", cnt inside {[9:13]}, 1);
		end
		u16_cyc = 1'h0;
		wait_for(3, 1'h0);
	endtask : cpu16
	task cpu8(input logic io, input logic [15:0] a);
		u8_addr = a;
		u8_io = io;
		u8_rd = $random(seed);
		u8_wr = !u8_rd;
		u8_cyc = 1'h1;
		wait_for(io ? 0 : 3, 1'h1);
		if (!io)
			chk("narrow_addr", bif.sys_addr, {cpu8_bank, a});
		u8_cyc = 1'h0;
		wait_for(3, 1'h0);
	endtask : cpu8
	task hand_down();
		cpu16(1'h1, {u16_addr[19:8], 8'hF0});
		wait_for(1, 1'h1);
		chk("narrow_own", bif.cpu16_grant, 0);
	endtask : hand_down
	// ====================
	// Main sequence.
	initial begin
		rst_b = 1'h0;
		{u16_cyc, u16_io, u16_rd, u16_wr, u8_cyc, u8_io, u8_rd, u8_wr, u_irq, u_dma_req, u_floppy_req, u_wait} = '0;
		{u_dma_cyc, u_dma_rd, u_dma_wr, u_refresh, u_dma_address_strobe, u_ob_cyc, u_ob_io, u_ob_rd, u_ob_wr, io_slow} = '0;
		{u16_addr, u_ob_addr, u8_addr, u_dma_addr, u_ob_req, cpu8_bank, dma_bank} = '0;
		repeat (20) @(negedge clk);
		rst_b = 1'h1;
		chk("grants", {bif.cpu16_grant, bif.cpu8_grant, bif.hlda, bif.ob_grant}, 7'h40);
		repeat (4) cpu16(1'h0, $random(seed));
		$display("test wide done");
		hand_down();
		cpu8_bank = $random(seed);
		repeat (3) cpu8(1'h0, $random(seed));
		cpu8(1'h1, $random(seed));
		chk("wide_back", bif.cpu8_grant, 0);
		hand_down();
		u_irq = 1'h1;
		wait_for(0, 1'h1);
		chk("irq_swap", bif.cpu8_grant, 0);
		u_irq = 1'h0;
		io_slow = 1'h1;
		cpu16(1'h1, 20'h00010);
		io_slow = 1'h0;
		$display("test swap done");
		hand_down();
		u_dma_req = 1'h1;
		wait_for(2, 1'h1);
		chk("cpus_off", {bif.cpu16_grant, bif.cpu8_grant}, 0);
		chk("owner_dma", owner_ff, 3);
		dma_bank = $random(seed);
		repeat (3) begin
			u_dma_addr = $random(seed);
			u_dma_address_strobe = 1'h1;
			@(negedge clk);
			u_dma_address_strobe = 1'h0;
			u_dma_rd = $random(seed);
			u_dma_wr = !u_dma_rd;
			u_dma_cyc = 1'h1;
			wait_for(3, 1'h1);
			chk("dma_addr", bif.sys_addr, {dma_bank, u_dma_addr});
			u_dma_cyc = 1'h0;
			wait_for(3, 1'h0);
		end
		u_dma_rd = 1'h0;
		u_dma_wr = 1'h0;
		u_refresh = 1'h1;
		u_dma_cyc = 1'h1;
		repeat (4) @(negedge clk);
		chk("refresh", {bif.sys_refresh, bif.sys_rd, bif.sys_wr}, 3'h4);
		u_refresh = 1'h0;
		u_dma_cyc = 1'h0;
		u_dma_req = 1'h0;
		wait_for(2, 1'h0);
		wait_for(1, 1'h1);
		chk("back_narrow", bif.cpu16_grant, 0);
		chk("owner_narrow", owner_ff, 1);
		$display("test active dma done");
		u_floppy_req = 1'h1;
		wait_for(6, 1'h1);
		wait_for(7, 1'h1);
		chk("floppy_own", {bif.cpu16_grant, bif.cpu8_grant, bif.hlda}, 3'h1);
		u_dma_rd = 1'h1;
		u_dma_cyc = 1'h1;
		wait_for(5, 1'h0);
		wait_for(5, 1'h1);
		chk("floppy_wait", cnt inside {[5:13]}, 1);
		u_dma_cyc = 1'h0;
		u_dma_rd = 1'h0;
		u_wait = 1'h1;
		repeat (20) @(negedge clk);
		chk("wait_line", bif.dma_ready, 0);
		u_wait = 1'h0;
		wait_for(5, 1'h1);
		u_floppy_req = 1'h0;
		wait_for(6, 1'h0);
		wait_for(1, 1'h1);
		$display("test passive dma done");
		for (int i = 0; i < 4; i++) begin
			u_ob_req = 4'h8 | (4'h1 << i);
			wait_for(8, 1'h1);
			chk("ob_grant", bif.ob_grant, low_bit(u_ob_req));
			u_ob_addr = $random(seed);
			u_ob_io = (i == 0);
			u_ob_rd = 1'h1;
			u_ob_cyc = 1'h1;
			repeat (4) @(negedge clk);
			chk("ob_strobe", {bif.sys_io, bif.sys_rd}, {1'h0, i != 0});
			chk("ob_refused", u_ob_io_refused_ff, i == 0);
			if (i != 0)
				chk("ob_addr", bif.sys_addr, u_ob_addr);
			u_ob_cyc = 1'h0;
			u_ob_req = 4'h0;
			wait_for(8, 1'h0);
		end
		wait_for(1, 1'h1);
		u_irq = 1'h1;
		wait_for(0, 1'h1);
		u_irq = 1'h0;
		u_dma_req = 1'h1;
		wait_for(2, 1'h1);
		u_dma_req = 1'h0;
		wait_for(0, 1'h1);
		chk("back_wide", {bif.cpu8_grant, owner_ff}, 3'h0);
		$display("test off board done");
		tally_and_finish();
	end
endmodule : bus_ownership_dma_arbiter_test
